// File: rtl/pllpc_regs.svh
`ifndef PLLPC_REGS_SVH
`define PLLPC_REGS_SVH

// Register offsets
`define OFS_NEAREST_CTRL 8'h03
`define OFS_DIVIDE_TO_8K_LOCK_PRI 8'h22
`define OFS_DIVIDE_TO_8K_LOCK_SEC 8'h23
`define OFS_SEC_FB 8'h35
`define OFS_BW_MODE 8'h3B
`define OFS_OUT_DIFF 8'h61
`define OFS_OUT_SE 8'h62
`define OFS_SEC_FREQ 8'h64
`define OFS_PATH_CFG 8'h65
`define OFS_LOCKED_BW 8'h67
`define OFS_ACQ_BW 8'h69
`define OFS_DAMPING 8'h6B
`define OFS_MULTI_CYC 8'h74
`define OFS_SYNC_SRC 8'h7A

// Slot of each register in the register array
`define REG_COUNT 14
`define RIDX_NEAREST 0
`define RIDX_DIVIDE_TO_8K_LOCK_PRI 1
`define RIDX_DIVIDE_TO_8K_LOCK_SEC 2
`define RIDX_SEC_FB 3
`define RIDX_BW_MODE 4
`define RIDX_OUT_DIFF 5
`define RIDX_OUT_SE 6
`define RIDX_SEC_FREQ 7
`define RIDX_PATH_CFG 8
`define RIDX_LOCKED_BW 9
`define RIDX_ACQ_BW 10
`define RIDX_DAMPING 11
`define RIDX_MULTI_CYC 12
`define RIDX_SYNC_SRC 13

// Reset values
`define RST_NEAREST 8'h00
`define RST_DIVIDE_TO_8K_LOCK 8'h00
`define RST_SEC_FB 8'h40
`define RST_BW_MODE 8'h80
`define RST_OUT_DIFF 8'h00
`define RST_OUT_SE 8'h02
`define RST_SEC_FREQ 8'h00
`define RST_PATH_CFG 8'h00
`define RST_LOCKED_BW 8'h01
`define RST_ACQ_BW 8'h02
`define RST_DAMPING 8'h04
`define RST_MULTI_CYC 8'hE0
`define RST_SYNC_SRC 8'h00

// Field positions
`define BIT_NE_INHIBIT 6
`define BIT_DIVIDE_TO_8K_LOCK 6
`define BIT_SEC_DIG_FB 6
`define BIT_AUTO_BW 7
`define BIT_MC_ENABLE 6
`define BIT_MC_INCLUDE 5
`define BIT_SYNC_SRC 7
`define BIT_SECOND_LOOP_INPUT_SELECTOR_LF 6
`define SECOND_LOOP_INPUT_SELECTOR_HI 5
`define SECOND_LOOP_INPUT_SELECTOR_LO 4
`define FIRST_LOOP_INPUT_SELECTOR_HI 2
`define FIRST_LOOP_INPUT_SELECTOR_LO 0
`define RANGE_HI 3
`define RANGE_LO 0
`define BW_HI 1
`define BW_LO 0
`define DAMP_HI 2
`define DAMP_LO 0
`define SECF_HI 2
`define SECF_LO 0
`define OUT_LOOP_BIT 4
`define OUT_DIV_HI 2
`define OUT_DIV_LO 0

// Field codes
`define FIRST_LOOP_INPUT_SELECTOR_DIGITAL 3'h1
`define FIRST_LOOP_INPUT_SELECTOR_LF_FIRST 3'h2
`define FIRST_LOOP_INPUT_SELECTOR_LF_LAST 3'h5
`define MC_MAX_STEP 4'hC

// Timing
`define SYS_CLK_HZ 40000000
`define LPF_CORNER_HZ 100
`define LPF_TAU_CYC (`SYS_CLK_HZ / (6 * `LPF_CORNER_HZ))

`endif

// File: rtl/pllpc_pkg.sv
package pllpc_pkg;
    // Loop bandwidth settings
    typedef enum logic [1:0] {BW_18HZ, BW_35HZ, BW_70HZ} pllpc_bw_t;
    // Damping factors
    typedef enum logic [2:0] {
        DAMP_1P2, DAMP_2P5, DAMP_5, DAMP_10, DAMP_20
    } pllpc_damp_t;
    // Source of the first analog loop input
    typedef enum logic [1:0] {
        FL_77M_ANALOG_FB, FL_77M_DIGITAL_FB, FL_LF_SYNTH
    } pllpc_fl_src_t;
    // Source of the second analog loop input
    typedef enum logic {SL_SECONDARY_LOOP, SL_LF_SYNTH} pllpc_sl_src_t;
    // E1/DS1 synthesis rates
    typedef enum logic [1:0] {
        LF_12E1, LF_16E1, LF_24DS1, LF_16DS1
    } pllpc_lf_rate_t;
endpackage

// File: rtl/pllpc_lpf.sv
`timescale 1ns/1ps
module pllpc_lpf #(
    parameter int W = 16, // Sample width
    parameter int TAU_CYCLES = 66666 // Filter time constant in clocks
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic signed [W-1:0] dataIn, // Raw sample every clock
    output logic signed [W-1:0] dataOut // Averaged value
);
    localparam int SHIFT = $clog2(TAU_CYCLES);
    localparam int AW = W + SHIFT;

    // Refuse a time constant the shifter cannot model
    if (TAU_CYCLES < 2) begin : g_bad_tau
        $error("pllpc_lpf: TAU_CYCLES must be at least 2");
    end

    logic signed [AW-1:0] acc_r;
    logic signed [AW-1:0] acc_nxt;
    logic signed [AW-1:0] inExt;
    logic signed [AW-1:0] leak;

    // First-order leaky integrator, gain one at DC
    assign inExt = AW'(dataIn);
    assign leak = acc_r >>> SHIFT;
    assign acc_nxt = acc_r + inExt - leak;

    // Accumulator and registered average
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            acc_r <= '0;
            dataOut <= '0;
        end else begin
            acc_r <= acc_nxt;
            dataOut <= W'(acc_r >>> SHIFT);
        end
    end
endmodule

// File: rtl/pllpc_out_sel.sv
`timescale 1ns/1ps
`include "pllpc_regs.svh"
module pllpc_out_sel #(
    parameter bit IS_DIFF = 1'b1 // Port is the differential output
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [7:0] selByte, // Output select register value
    output logic [6:0] divRatio, // Chosen divide ratio, zero if off
    output logic fromSecond, // Chosen tap is on the second loop
    output logic selValid // Selection is offered on this port
);
    logic [2:0] divIdx;
    logic loopSel;
    logic [6:0] firstRatio;
    logic [6:0] secondRatio;
    logic offered;

    assign divIdx = selByte[`OUT_DIV_HI:`OUT_DIV_LO];
    assign loopSel = selByte[`OUT_LOOP_BIT];

    // Divider taps of the first analog loop
    assign firstRatio = (divIdx == 3'h0) ? 7'h01 :
                        (divIdx == 3'h1) ? 7'h02 :
                        (divIdx == 3'h2) ? 7'h04 :
                        (divIdx == 3'h3) ? 7'h06 :
                        (divIdx == 3'h4) ? 7'h08 :
                        (divIdx == 3'h5) ? 7'h0C :
                        (divIdx == 3'h6) ? 7'h10 : 7'h30;
    // Divider taps of the second analog loop
    assign secondRatio = (divIdx == 3'h0) ? 7'h02 :
                         (divIdx == 3'h1) ? 7'h04 :
                         (divIdx == 3'h2) ? 7'h08 :
                         (divIdx == 3'h3) ? 7'h0C :
                         (divIdx == 3'h4) ? 7'h10 :
                         (divIdx == 3'h5) ? 7'h30 :
                         (divIdx == 3'h6) ? 7'h40 : 7'h00;

    // Port restrictions on first loop taps
    assign offered = loopSel ? (secondRatio != 7'h00) :
                     IS_DIFF ? (firstRatio != 7'h30) :
                     (firstRatio > 7'h02);

    // Registered selection, ratio squelched when not offered
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            divRatio <= 7'h00;
            fromSecond <= 1'b0;
            selValid <= 1'b0;
        end else begin
            divRatio <= offered ? (loopSel ? secondRatio : firstRatio)
                                : 7'h00;
            fromSecond <= loopSel;
            selValid <= offered;
        end
    end
endmodule

// File: rtl/pllpc_top.sv
`timescale 1ns/1ps
`include "pllpc_regs.svh"
module pllpc_top #(
    parameter int LPF_TAU_CYC = `LPF_TAU_CYC, // Filter time constant
    parameter int FRAC_W = 8, // Fraction bits in one UI
    parameter int MC_W = 14 // Multi-cycle count width
) (
    input wire logic sys_clk, // System clock, 40 MHz
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [7:0] regAddr, // Register offset
    input wire logic regWrEn, // Write strobe
    input wire logic [7:0] regWrData, // Write data
    input wire logic regRdEn, // Read strobe
    output logic [7:0] regRdData, // Read data, held
    input wire logic freqLocked, // Frequency lock from detectors
    input wire logic phaseLocked, // Phase lock from detectors
    input wire logic refIs155m, // Reference runs at 155.52 MHz
    input wire logic signed [FRAC_W+1:0] pfdErr, // Single-cycle error
    input wire logic signed [MC_W-1:0] mcCycles, // Whole-cycle error
    output pllpc_pkg::pllpc_fl_src_t firstLoopSrc, // First loop input
    output pllpc_pkg::pllpc_lf_rate_t firstLoopRate, // Its E1/DS1 rate
    output logic primaryFbAnalog, // Primary uses analog feedback
    output pllpc_pkg::pllpc_sl_src_t secondLoopSrc, // Second loop input
    output pllpc_pkg::pllpc_lf_rate_t secondLoopRate, // Its E1/DS1 rate
    output logic [2:0] secLoopFreqCode, // Secondary loop frequency
    output logic secFbFromAnalog, // Secondary feedback via analog
    output logic lfClkFromFirstLoop, // Synthesis clock source
    output logic lfRateConflict, // Both selectors disagree on rate
    output logic [6:0] diffDivRatio, // Differential divide ratio
    output logic diffFromSecond, // Differential tap loop
    output logic diffValid, // Differential selection offered
    output logic [6:0] seDivRatio, // Single-ended divide ratio
    output logic seFromSecond, // Single-ended tap loop
    output logic seValid, // Single-ended selection offered
    output logic lowClkFromSecondary, // 2/8 kHz clocks source
    output logic syncFromPrimary, // Sync outputs source
    output logic useAcqBw, // Acquisition bandwidth active
    output pllpc_pkg::pllpc_bw_t activeBw, // Bandwidth in use
    output pllpc_pkg::pllpc_damp_t dampFactor, // Damping in use
    output logic nearestEdge, // Nearest edge capture active
    output logic mcEnable, // Multi-cycle detector on
    output logic mcIncludeLoop, // Multi-cycle value in loop
    output logic [12:0] mcRangeUi, // Multi-cycle range in UI
    output logic lock8kPrimary, // Primary divides to 8 kHz
    output logic lock8kSecondary, // Secondary divides to 8 kHz
    output logic refHalve, // Reference halved to 77.76 MHz
    output logic signed [MC_W+FRAC_W:0] avgPhaseErr // Filtered error
);
    localparam int ERR_W = MC_W + FRAC_W + 1;

    // Range needs 13 bits plus sign
    if (MC_W < 14 || FRAC_W < 1) begin : g_bad_width
        $error("pllpc_top: MC_W must be 14 or more, FRAC_W 1 or more");
    end

    localparam logic [7:0] REG_OFS [`REG_COUNT] = '{
        `OFS_NEAREST_CTRL, `OFS_DIVIDE_TO_8K_LOCK_PRI, `OFS_DIVIDE_TO_8K_LOCK_SEC, `OFS_SEC_FB,
        `OFS_BW_MODE, `OFS_OUT_DIFF, `OFS_OUT_SE, `OFS_SEC_FREQ,
        `OFS_PATH_CFG, `OFS_LOCKED_BW, `OFS_ACQ_BW, `OFS_DAMPING,
        `OFS_MULTI_CYC, `OFS_SYNC_SRC};
    localparam logic [7:0] REG_RST [`REG_COUNT] = '{
        `RST_NEAREST, `RST_DIVIDE_TO_8K_LOCK, `RST_DIVIDE_TO_8K_LOCK, `RST_SEC_FB,
        `RST_BW_MODE, `RST_OUT_DIFF, `RST_OUT_SE, `RST_SEC_FREQ,
        `RST_PATH_CFG, `RST_LOCKED_BW, `RST_ACQ_BW, `RST_DAMPING,
        `RST_MULTI_CYC, `RST_SYNC_SRC};

    logic [7:0] regFile_r [`REG_COUNT];
    logic [`REG_COUNT-1:0] regHit;
    logic [7:0] rdTerm [`REG_COUNT];
    logic [7:0] rdAny;

    // Register array with address decode
    for (genvar gi = 0; gi < `REG_COUNT; gi++) begin : g_reg
        assign regHit[gi] = (regAddr == REG_OFS[gi]);
        assign rdTerm[gi] = regHit[gi] ? regFile_r[gi] : 8'h00;
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                regFile_r[gi] <= REG_RST[gi];
            end else if (regWrEn && regHit[gi]) begin
                regFile_r[gi] <= regWrData;
            end
        end
    end

    // Read merge, unmapped offsets give zero
    always_comb begin
        rdAny = 8'h00;
        for (int i = 0; i < `REG_COUNT; i++) begin
            rdAny = rdAny | rdTerm[i];
        end
    end

    // E1/DS1 rate from a two-bit code
    function automatic pllpc_pkg::pllpc_lf_rate_t lfRate(
        input logic [1:0] code);
        case (code)
            2'h0: lfRate = pllpc_pkg::LF_12E1;
            2'h1: lfRate = pllpc_pkg::LF_16E1;
            2'h2: lfRate = pllpc_pkg::LF_24DS1;
            default: lfRate = pllpc_pkg::LF_16DS1;
        endcase
    endfunction

    // Bandwidth from a two-bit code, spare code as widest
    function automatic pllpc_pkg::pllpc_bw_t bwOf(input logic [1:0] code);
        case (code)
            2'h0: bwOf = pllpc_pkg::BW_18HZ;
            2'h1: bwOf = pllpc_pkg::BW_35HZ;
            default: bwOf = pllpc_pkg::BW_70HZ;
        endcase
    endfunction

    // Damping from code and bandwidth
    function automatic pllpc_pkg::pllpc_damp_t dampOf(
        input pllpc_pkg::pllpc_bw_t bw, input logic [2:0] code);
        case (code)
            3'h1: dampOf = pllpc_pkg::DAMP_1P2;
            3'h2: dampOf = pllpc_pkg::DAMP_2P5;
            3'h4: dampOf = (bw == pllpc_pkg::BW_18HZ) ?
                pllpc_pkg::DAMP_5 : pllpc_pkg::DAMP_10;
            3'h5: dampOf = (bw == pllpc_pkg::BW_18HZ) ? pllpc_pkg::DAMP_5 :
                (bw == pllpc_pkg::BW_35HZ) ? pllpc_pkg::DAMP_10 :
                pllpc_pkg::DAMP_20;
            default: dampOf = pllpc_pkg::DAMP_5;
        endcase
    endfunction

    // Named register fields
    logic [7:0] cfgPath;
    logic [2:0] mux1Code;
    logic [1:0] mux2Code;
    logic [1:0] mux1RateCode;
    logic firstLf;
    logic secondLf;
    logic autoBw;
    logic inhibitNe;
    logic mcEnBit;
    logic mcIncBit;
    logic [3:0] rangeCode;
    logic [2:0] dampCode;
    assign cfgPath = regFile_r[`RIDX_PATH_CFG];
    assign mux1Code = cfgPath[`FIRST_LOOP_INPUT_SELECTOR_HI:`FIRST_LOOP_INPUT_SELECTOR_LO];
    assign mux2Code = cfgPath[`SECOND_LOOP_INPUT_SELECTOR_HI:`SECOND_LOOP_INPUT_SELECTOR_LO];
    assign mux1RateCode = 2'(mux1Code - `FIRST_LOOP_INPUT_SELECTOR_LF_FIRST);
    assign firstLf = (mux1Code >= `FIRST_LOOP_INPUT_SELECTOR_LF_FIRST) &&
                     (mux1Code <= `FIRST_LOOP_INPUT_SELECTOR_LF_LAST);
    assign secondLf = cfgPath[`BIT_SECOND_LOOP_INPUT_SELECTOR_LF];
    assign autoBw = regFile_r[`RIDX_BW_MODE][`BIT_AUTO_BW];
    assign inhibitNe = regFile_r[`RIDX_NEAREST][`BIT_NE_INHIBIT];
    assign mcEnBit = regFile_r[`RIDX_MULTI_CYC][`BIT_MC_ENABLE];
    assign mcIncBit = regFile_r[`RIDX_MULTI_CYC][`BIT_MC_INCLUDE];
    assign rangeCode = regFile_r[`RIDX_MULTI_CYC][`RANGE_HI:`RANGE_LO];
    assign dampCode = regFile_r[`RIDX_DAMPING][`DAMP_HI:`DAMP_LO];

    // Analog loop input selection; no secondary path to first loop
    pllpc_pkg::pllpc_fl_src_t firstSrc_nxt;
    pllpc_pkg::pllpc_sl_src_t secondSrc_nxt;
    assign firstSrc_nxt = firstLf ? pllpc_pkg::FL_LF_SYNTH :
        (mux1Code == `FIRST_LOOP_INPUT_SELECTOR_DIGITAL) ? pllpc_pkg::FL_77M_DIGITAL_FB :
        pllpc_pkg::FL_77M_ANALOG_FB;
    assign secondSrc_nxt = secondLf ? pllpc_pkg::SL_LF_SYNTH :
        pllpc_pkg::SL_SECONDARY_LOOP;

    // Bandwidth and damping in use
    pllpc_pkg::pllpc_bw_t bw_nxt;
    logic useAcq_nxt;
    assign useAcq_nxt = autoBw && !freqLocked;
    assign bw_nxt = useAcq_nxt ?
        bwOf(regFile_r[`RIDX_ACQ_BW][`BW_HI:`BW_LO]) :
        bwOf(regFile_r[`RIDX_LOCKED_BW][`BW_HI:`BW_LO]);

    // Multi-cycle range grows by powers of two
    logic [3:0] rangeStep;
    logic [12:0] range_nxt;
    assign rangeStep = (rangeCode > `MC_MAX_STEP) ? `MC_MAX_STEP : rangeCode;
    assign range_nxt = 13'((14'h1 << (rangeStep + 4'h1)) - 14'h1);

    // Phase error into the loop: clamp, then optional multi-cycle term
    logic signed [MC_W-1:0] rangeS;
    logic signed [MC_W-1:0] mcClamp;
    logic signed [FRAC_W+1:0] oneUi;
    logic signed [FRAC_W+1:0] pfdClamp;
    logic signed [ERR_W-1:0] loopErr;
    assign rangeS = MC_W'(range_nxt);
    assign mcClamp = (mcCycles > rangeS) ? rangeS :
                     (mcCycles < -rangeS) ? -rangeS : mcCycles;
    assign oneUi = (FRAC_W + 2)'(1) <<< FRAC_W;
    assign pfdClamp = (pfdErr > oneUi) ? oneUi :
                      (pfdErr < -oneUi) ? -oneUi : pfdErr;
    assign loopErr = (mcEnBit && mcIncBit) ?
        (ERR_W'(mcClamp) <<< FRAC_W) + ERR_W'(pfdClamp) :
        ERR_W'(pfdClamp);

    // Averaging of the detector error before the loop filter
    pllpc_lpf #(.W(ERR_W), .TAU_CYCLES(LPF_TAU_CYC)) u_lpf (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .dataIn(loopErr),
        .dataOut(avgPhaseErr)
    );

    // Output port divider selection
    pllpc_out_sel #(.IS_DIFF(1'b1)) u_sel_diff (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .selByte(regFile_r[`RIDX_OUT_DIFF]),
        .divRatio(diffDivRatio),
        .fromSecond(diffFromSecond),
        .selValid(diffValid)
    );
    pllpc_out_sel #(.IS_DIFF(1'b0)) u_sel_se (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .selByte(regFile_r[`RIDX_OUT_SE]),
        .divRatio(seDivRatio),
        .fromSecond(seFromSecond),
        .selValid(seValid)
    );

    // Divide-to-8k bit, read ahead of its own output register
    logic lock8kPrimary_nxt;
    assign lock8kPrimary_nxt = regFile_r[`RIDX_DIVIDE_TO_8K_LOCK_PRI][`BIT_DIVIDE_TO_8K_LOCK];

    // Registered control outputs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            regRdData <= 8'h00;
            firstLoopSrc <= pllpc_pkg::FL_77M_ANALOG_FB;
            firstLoopRate <= pllpc_pkg::LF_12E1;
            primaryFbAnalog <= 1'b1;
            secondLoopSrc <= pllpc_pkg::SL_SECONDARY_LOOP;
            secondLoopRate <= pllpc_pkg::LF_12E1;
            secLoopFreqCode <= 3'h0;
            secFbFromAnalog <= 1'b0;
            lfClkFromFirstLoop <= 1'b1;
            lfRateConflict <= 1'b0;
            lowClkFromSecondary <= 1'b0;
            syncFromPrimary <= 1'b1;
            useAcqBw <= 1'b1;
            activeBw <= pllpc_pkg::BW_70HZ;
            dampFactor <= pllpc_pkg::DAMP_10;
            nearestEdge <= 1'b0;
            mcEnable <= 1'b0;
            mcIncludeLoop <= 1'b0;
            mcRangeUi <= 13'h0001;
            lock8kPrimary <= 1'b0;
            lock8kSecondary <= 1'b0;
            refHalve <= 1'b0;
        end else begin
            regRdData <= regRdEn ? rdAny : regRdData;
            firstLoopSrc <= firstSrc_nxt;
            firstLoopRate <= lfRate(mux1RateCode);
            primaryFbAnalog <= (mux1Code != `FIRST_LOOP_INPUT_SELECTOR_DIGITAL);
            secondLoopSrc <= secondSrc_nxt;
            secondLoopRate <= lfRate(mux2Code);
            secLoopFreqCode <= regFile_r[`RIDX_SEC_FREQ][`SECF_HI:`SECF_LO];
            secFbFromAnalog <=
                !regFile_r[`RIDX_SEC_FB][`BIT_SEC_DIG_FB];
            lfClkFromFirstLoop <= !firstLf;
            lfRateConflict <= firstLf && secondLf &&
                (mux1RateCode != mux2Code);
            lowClkFromSecondary <=
                regFile_r[`RIDX_SYNC_SRC][`BIT_SYNC_SRC];
            syncFromPrimary <= 1'b1;
            useAcqBw <= useAcq_nxt;
            activeBw <= bw_nxt;
            dampFactor <= dampOf(bw_nxt, dampCode);
            nearestEdge <= !inhibitNe && !mcEnBit && phaseLocked;
            mcEnable <= mcEnBit;
            mcIncludeLoop <= mcEnBit && mcIncBit;
            mcRangeUi <= range_nxt;
            lock8kPrimary <=
                regFile_r[`RIDX_DIVIDE_TO_8K_LOCK_PRI][`BIT_DIVIDE_TO_8K_LOCK];
            lock8kSecondary <= regFile_r[`RIDX_DIVIDE_TO_8K_LOCK_SEC][`BIT_DIVIDE_TO_8K_LOCK];
            refHalve <= refIs155m && !lock8kPrimary_nxt;
        end
    end

    // Checks on the control decode
    nearest_edge_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (phaseLocked && !inhibitNe && !mcEnBit) |=> nearestEdge)
        else $error("nearest edge not selected when locked");
    ne_inhibit_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        inhibitNe |=> !nearestEdge)
        else $error("nearest edge selected while inhibited");
    acq_bw_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (autoBw && !freqLocked) |=> useAcqBw &&
        activeBw == bwOf($past(regFile_r[`RIDX_ACQ_BW][`BW_HI:`BW_LO])))
        else $error("acquisition bandwidth not used before lock");
    reset_defaults_a: assert property (
        @(posedge sys_clk)
        !resetn |=> regFile_r[`RIDX_ACQ_BW] == `RST_ACQ_BW &&
        regFile_r[`RIDX_PATH_CFG] == `RST_PATH_CFG ##1
        (resetn && !regWrEn) [*1] |-> primaryFbAnalog)
        else $error("reset defaults wrong");
    loop_err_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !(mcEnBit && mcIncBit) |->
        (loopErr <= ERR_W'(oneUi) && loopErr >= -ERR_W'(oneUi)))
        else $error("loop error exceeds one cycle");
    second_loop_input_selector_path_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        secondLf |=> secondLoopSrc == pllpc_pkg::SL_LF_SYNTH &&
        secondLoopRate == lfRate($past(mux2Code)))
        else $error("second loop input decode wrong");
    first_loop_input_selector_digital_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (mux1Code == `FIRST_LOOP_INPUT_SELECTOR_DIGITAL) |=>
        firstLoopSrc == pllpc_pkg::FL_77M_DIGITAL_FB && !primaryFbAnalog)
        else $error("digital feedback path decode wrong");
    lf_clock_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (firstLoopSrc == pllpc_pkg::FL_LF_SYNTH) |-> !lfClkFromFirstLoop)
        else $error("synthesis clock loops through first loop");
    port_taps_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (diffValid && !diffFromSecond |-> diffDivRatio != 7'h30) and
        (seValid && !seFromSecond |-> seDivRatio > 7'h02))
        else $error("tap offered on wrong port");
    damping_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (bw_nxt == pllpc_pkg::BW_18HZ && dampCode == 3'h5) |=>
        dampFactor == pllpc_pkg::DAMP_5)
        else $error("damping above limit at 18 Hz");
    mc_range_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (rangeCode >= `MC_MAX_STEP) [*2] |-> mcRangeUi == 13'h1FFF)
        else $error("multi-cycle range top wrong");
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`include "pllpc_regs.svh"
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errTotal++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb;
    logic sys_clk = 1'b0, resetn = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
    logic freqLocked = 1'b0, phaseLocked = 1'b0, ref155 = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdData, d;
    logic signed [9:0] pfdErr = 10'h000;
    logic signed [13:0] mcCycles = 14'h0000;
    logic [15:0] lf = 16'h113A;
    pllpc_pkg::pllpc_fl_src_t flSrc;
    pllpc_pkg::pllpc_lf_rate_t flRate, slRate;
    pllpc_pkg::pllpc_sl_src_t slSrc;
    pllpc_pkg::pllpc_bw_t bw;
    pllpc_pkg::pllpc_damp_t damp;
    logic fbAna, acq, near, syncPri, lowSec, secFbAna, lfClkFirst, rateConf;
    logic diffSec, diffOk, seSec, seOk, mcEn, mcInc, l8kP, l8kS, refHalf, v;
    logic [2:0] secFreq;
    logic [6:0] diffRatio, seRatio, e;
    logic signed [22:0] avgErr;
    logic [12:0] mcUi;
    int errTotal = 0, nCompared = 0;
    // Next state of the stimulus shift register
    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Clock and random detector inputs
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        #1;
        lf <= lfsrNext(lf);
        pfdErr <= lf[9:0];
        mcCycles <= lf[15:2];
        ref155 <= lf[0];
    end
    pllpc_top #(.LPF_TAU_CYC(16)) u_pllpc_top (.sys_clk(sys_clk),
        .resetn(resetn), .regAddr(addr), .regWrEn(wrEn), .regWrData(wdata),
        .regRdEn(rdEn), .regRdData(rdData), .freqLocked(freqLocked),
        .phaseLocked(phaseLocked), .refIs155m(ref155), .pfdErr(pfdErr),
        .mcCycles(mcCycles), .firstLoopSrc(flSrc), .firstLoopRate(flRate),
        .primaryFbAnalog(fbAna), .secondLoopSrc(slSrc),
        .secondLoopRate(slRate), .secLoopFreqCode(secFreq),
        .secFbFromAnalog(secFbAna), .lfClkFromFirstLoop(lfClkFirst),
        .lfRateConflict(rateConf), .diffDivRatio(diffRatio),
        .diffFromSecond(diffSec), .diffValid(diffOk), .seDivRatio(seRatio),
        .seFromSecond(seSec), .seValid(seOk),
        .lowClkFromSecondary(lowSec), .syncFromPrimary(syncPri),
        .useAcqBw(acq), .activeBw(bw), .dampFactor(damp), .nearestEdge(near),
        .mcEnable(mcEn), .mcIncludeLoop(mcInc), .mcRangeUi(mcUi),
        .lock8kPrimary(l8kP), .lock8kSecondary(l8kS), .refHalve(refHalf),
        .avgPhaseErr(avgErr));
    // Expected damping for a bandwidth code and damping code
    function automatic pllpc_pkg::pllpc_damp_t dampExp(input int b, c);
        if (c == 1) return pllpc_pkg::DAMP_1P2;
        if (c == 2) return pllpc_pkg::DAMP_2P5;
        if (c < 4 || c > 5 || b == 0) return pllpc_pkg::DAMP_5;
        if (b == 1 || c == 4) return pllpc_pkg::DAMP_10;
        return pllpc_pkg::DAMP_20;
    endfunction
    // Divide ratio of a tap, zero where the loop has none
    function automatic logic [6:0] tapExp(input logic s, input int i);
        int r1 [8] = '{1, 2, 4, 6, 8, 12, 16, 48};
        int r2 [8] = '{2, 4, 8, 12, 16, 48, 64, 0};
        return 7'(s ? r2[i] : r1[i]);
    endfunction
    // Register port cycles
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, v);
        addr = a; wdata = v; wrEn = 1'b1; cyc(1); wrEn = 1'b0; cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, e);
        addr = a; rdEn = 1'b1; cyc(1); rdEn = 1'b0; cyc(1);
        `CHK(rdData, e)
    endtask
    task automatic endSim;
        if (errTotal == 0 && nCompared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #2000000;
        errTotal++;
        endSim;
    end
    // Main sequence
    initial begin
        cyc(8); resetn = 1'b1; cyc(2);
        `CHK(fbAna, 1'b1)
        `CHK(acq, 1'b1)
        `CHK(bw, pllpc_pkg::BW_70HZ)
        `CHK(syncPri, 1'b1)
        rd(`OFS_MULTI_CYC, `RST_MULTI_CYC);
        rd(`OFS_ACQ_BW, `RST_ACQ_BW);
        rd(8'h66, 8'h00);
        for (int c = 0; c < 6; c++) begin
            wr(`OFS_PATH_CFG, 8'(c));
            `CHK(flSrc, pllpc_pkg::pllpc_fl_src_t'(c > 2 ? 2 : c))
            `CHK(lfClkFirst, c < 2)
            if (c > 1) `CHK(flRate, 2'(c - 2))
            `CHK(fbAna, c != 1)
        end
        for (int c = 0; c < 8; c++) begin
            wr(`OFS_PATH_CFG, {1'b0, c[2], c[1:0], 4'h0});
            `CHK(slSrc, pllpc_pkg::pllpc_sl_src_t'(c[2]))
            if (c[2]) `CHK(slRate, c[1:0])
        end
        for (int b = 0; b < 4; b++) for (int c = 0; c < 8; c++) begin
            wr(`OFS_ACQ_BW, 8'(b)); wr(`OFS_DAMPING, 8'(c));
            `CHK(bw, pllpc_pkg::pllpc_bw_t'(b > 2 ? 2 : b))
            `CHK(damp, dampExp(b, c))
        end
        wr(`OFS_LOCKED_BW, 8'h00); freqLocked = 1'b1; cyc(2);
        `CHK(acq, 1'b0)
        `CHK(bw, pllpc_pkg::BW_18HZ)
        wr(`OFS_MULTI_CYC, 8'h00); phaseLocked = 1'b1; cyc(2);
        `CHK(near, 1'b1)
        wr(`OFS_NEAREST_CTRL, 8'h40);
        `CHK(near, 1'b0)
        wr(`OFS_NEAREST_CTRL, 8'h00); wr(`OFS_MULTI_CYC, 8'h40);
        `CHK(near, 1'b0)
        for (int i = 0; i < 16; i++) begin
            wr(`OFS_MULTI_CYC, 8'(8'h40 | i));
            `CHK(mcUi, 13'((1 << ((i > 12 ? 12 : i) + 1)) - 1))
            `CHK(mcEn, 1'b1)
            `CHK(mcInc, 1'b0)
        end
        for (int k = 0; k < 16; k++) begin
            e = tapExp(k >= 8, k % 8);
            wr(`OFS_OUT_DIFF, 8'(k / 8 * 16 + k % 8));
            wr(`OFS_OUT_SE, 8'(k / 8 * 16 + k % 8));
            v = e != 7'h00 && (k >= 8 || e != 7'h30);
            `CHK(diffOk, v)
            `CHK(diffRatio, v ? e : 7'h00)
            `CHK(diffSec, k >= 8)
            v = e != 7'h00 && (k >= 8 || e > 7'h02);
            `CHK(seOk, v)
            `CHK(seRatio, v ? e : 7'h00)
            `CHK(seSec, k >= 8)
        end
        wr(`OFS_PATH_CFG, 8'h64);
        `CHK(rateConf, 1'b0)
        `CHK(flRate, pllpc_pkg::LF_24DS1)
        `CHK(slRate, pllpc_pkg::LF_24DS1)
        `CHK(lfClkFirst, 1'b0)
        repeat (4) begin
            d = lf[7:0]; wr(`OFS_SYNC_SRC, d);
            `CHK(lowSec, d[7])
            rd(`OFS_SYNC_SRC, d);
            wr(`OFS_DIVIDE_TO_8K_LOCK_PRI, d);
            wr(`OFS_DIVIDE_TO_8K_LOCK_SEC, ~d);
            wr(`OFS_SEC_FB, d);
            wr(`OFS_SEC_FREQ, d);
            `CHK(l8kP, d[6])
            `CHK(l8kS, !d[6])
            `CHK(refHalf, ref155 && !d[6])
            `CHK(secFbAna, !d[6])
            `CHK(secFreq, d[2:0])
            `CHK(avgErr <= 256 && avgErr >= -256, 1'b1)
        end
        wr(`OFS_MULTI_CYC, 8'h60);
        `CHK(mcEn, 1'b1)
        `CHK(mcInc, 1'b1)
        endSim;
    end
endmodule
